// ==== hdl/rmc_modem.sv ====
module rmc_modem #(
    parameter int BIT_CYC = rmc_pkg::BIT_CYC
) (
    // clock and reset
    input  wire logic                CORE_CLK,
    input  wire logic                SYS_RST,
    // host link
    rmc_link_if.modem                link,
    // stored defaults
    input  wire logic [2:0]          NV_ADDR,
    input  wire logic [2:0]          NV_CHAN,
    input  wire logic                NV_DONE,
    output logic                     NV_WR,
    // node setting
    output logic [2:0]               NODE_ADDR,
    output logic [2:0]               NODE_CHAN,
    // radio side
    output logic                     RF_LINK_EN,
    output logic                     RF_TX_VALID,
    output logic [7:0]               RF_TX_DATA,
    output rmc_pkg::rmc_tone_e       RF_TONE,
    input  wire logic                RF_RX_VALID,
    input  wire logic [7:0]          RF_RX_DATA,
    input  wire logic [2:0]          RF_RX_ADDR,
    input  wire logic [2:0]          RF_RX_CHAN
);

    localparam rmc_pkg::rmc_cnt_t BIT_LAST = rmc_pkg::rmc_cnt_t'(BIT_CYC - 1);
    localparam rmc_pkg::rmc_cnt_t BIT_HALF = rmc_pkg::rmc_cnt_t'(BIT_CYC / 2);

    typedef struct packed {
        logic                loaded;
        logic [2:0]          addr;
        logic [2:0]          chan;
        rmc_pkg::rmc_tone_e  tone;
        logic                rx_busy;
        rmc_pkg::rmc_cnt_t   rx_cnt;
        logic [3:0]          rx_bit;
        logic [7:0]          rx_sh;
        logic                tx_busy;
        rmc_pkg::rmc_cnt_t   tx_cnt;
        logic [3:0]          tx_bit;
        logic [9:0]          tx_sh;
        logic                rxd;
        logic [79:0]         cbuf;
        logic [3:0]          clen;
        logic                echo_pend;
        logic [7:0]          echo_ch;
        logic                tilde_pend;
        logic                nv_busy;
        logic                nv_wr;
        logic                buf_valid;
        logic [7:0]          buf_ch;
        logic                status;
        logic                link_en;
        logic                rf_tx_valid;
        logic [7:0]          rf_tx_data;
    } rmc_modem_s;

    rmc_modem_s s_reg;
    rmc_modem_s s_next;
    logic       enabled;
    logic       setup;
    logic       normal;
    logic       rx_done;
    logic       tx_go;
    logic [7:0] tx_ch;
    logic [7:0] digit;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_next             = s_reg;
        s_next.rf_tx_valid = 1'b0;
        s_next.nv_wr       = 1'b0;
        rx_done            = 1'b0;
        tx_go              = 1'b0;
        tx_ch              = 8'h00;
        digit              = s_reg.cbuf[7:0] - rmc_pkg::CH_ZERO;
        enabled            = !link.enable_n && s_reg.loaded;
        setup              = enabled && !link.setup_n;
        normal             = enabled && link.setup_n;

        if (!s_reg.loaded) begin
            s_next.loaded = 1'b1;
            s_next.addr   = NV_ADDR;
            s_next.chan   = NV_CHAN;
        end

        if (!s_reg.rx_busy) begin
            if (enabled && !link.txd) begin
                s_next.rx_busy = 1'b1;
                s_next.rx_cnt  = BIT_HALF;
                s_next.rx_bit  = 4'h0;
            end
        end else if (s_reg.rx_cnt != '0) begin
            s_next.rx_cnt = s_reg.rx_cnt - 1'b1;
        end else begin
            s_next.rx_cnt = BIT_LAST;
            s_next.rx_bit = s_reg.rx_bit + 1'b1;
            if (s_reg.rx_bit == 4'h0) begin
                s_next.rx_busy = !link.txd;
            end else if (s_reg.rx_bit == rmc_pkg::RX_STOP_IDX) begin
                s_next.rx_busy = 1'b0;
                rx_done        = link.txd;
            end else begin
                s_next.rx_sh = {link.txd, s_reg.rx_sh[7:1]};
            end
        end

        // transmitter, one stop bit
        if (s_reg.tx_busy) begin
            if (s_reg.tx_cnt != '0) begin
                s_next.tx_cnt = s_reg.tx_cnt - 1'b1;
            end else if (s_reg.tx_bit == 4'h0) begin
                s_next.tx_busy = 1'b0;
                s_next.rxd     = 1'b1;
            end else begin
                s_next.tx_sh  = {1'b1, s_reg.tx_sh[9:1]};
                s_next.rxd    = s_reg.tx_sh[1];
                s_next.tx_bit = s_reg.tx_bit - 1'b1;
                s_next.tx_cnt = BIT_LAST;
            end
        end else if (s_reg.echo_pend) begin
            tx_go            = 1'b1;
            tx_ch            = s_reg.echo_ch;
            s_next.echo_pend = 1'b0;
        end else if (s_reg.tilde_pend) begin
            tx_go             = 1'b1;
            tx_ch             = rmc_pkg::CH_TILDE;
            s_next.tilde_pend = 1'b0;
        end else if (normal && s_reg.buf_valid) begin
            tx_go            = 1'b1;
            tx_ch            = s_reg.buf_ch;
            s_next.buf_valid = 1'b0;
        end
        if (tx_go) begin
            s_next.tx_busy = 1'b1;
            s_next.tx_sh   = {1'b1, tx_ch, 1'b0};
            s_next.rxd     = 1'b0;
            s_next.tx_bit  = rmc_pkg::TX_LAST_IDX;
            s_next.tx_cnt  = BIT_LAST;
        end

        if (s_reg.nv_busy && NV_DONE) begin
            s_next.nv_busy    = 1'b0;
            s_next.tilde_pend = 1'b1;
        end

        if (normal && RF_RX_VALID && RF_RX_ADDR == s_reg.addr && RF_RX_CHAN == s_reg.chan) begin
            s_next.buf_valid = 1'b1;
            s_next.buf_ch    = RF_RX_DATA;
        end

        if (rx_done && setup) begin
            s_next.echo_pend = 1'b1;
            s_next.echo_ch   = s_reg.rx_sh;
            if (s_reg.rx_sh == rmc_pkg::CH_CR) begin
                s_next.clen = 4'h0;
                s_next.cbuf = '0;
                if (s_reg.clen == rmc_pkg::LEN_SEL && s_reg.cbuf[39:8] == rmc_pkg::CMD_ADDR
                    && s_reg.cbuf[7:0] >= rmc_pkg::CH_ZERO && s_reg.cbuf[7:0] <= rmc_pkg::CH_ADDR_MAX) begin
                    s_next.addr = digit[2:0];
                end
                if (s_reg.clen == rmc_pkg::LEN_SEL && s_reg.cbuf[39:8] == rmc_pkg::CMD_CHAN
                    && s_reg.cbuf[7:0] >= rmc_pkg::CH_ZERO && s_reg.cbuf[7:0] <= rmc_pkg::CH_CHAN_MAX) begin
                    s_next.chan = digit[2:0];
                end
                if (s_reg.clen == rmc_pkg::LEN_SAVE && s_reg.cbuf == rmc_pkg::CMD_SAVE) begin
                    s_next.nv_wr   = 1'b1;
                    s_next.nv_busy = 1'b1;
                end
                if (s_reg.clen == rmc_pkg::LEN_TONE && s_reg.cbuf[47:0] == rmc_pkg::CMD_PLAIN) begin
                    s_next.tone = rmc_pkg::TONE_PLAIN;
                end
                if (s_reg.clen == rmc_pkg::LEN_TONE && s_reg.cbuf[47:0] == rmc_pkg::CMD_LOW) begin
                    s_next.tone = rmc_pkg::TONE_LOW;
                end
                if (s_reg.clen == rmc_pkg::LEN_TONE && s_reg.cbuf[47:0] == rmc_pkg::CMD_HIGH) begin
                    s_next.tone = rmc_pkg::TONE_HIGH;
                end
                if (s_reg.clen == rmc_pkg::LEN_HASH && s_reg.cbuf[7:0] == rmc_pkg::CH_HASH) begin
                    s_next.tone = rmc_pkg::TONE_OFF;
                end
            end else begin
                s_next.cbuf = {s_reg.cbuf[71:0], s_reg.rx_sh};
                if (s_reg.clen != rmc_pkg::LEN_OVER) begin
                    s_next.clen = s_reg.clen + 1'b1;
                end
            end
        end

        // host byte goes straight out, no throttle
        if (rx_done && normal) begin
            s_next.rf_tx_valid = 1'b1;
            s_next.rf_tx_data  = s_reg.rx_sh;
            s_next.buf_valid   = 1'b0;
        end

        if (!setup) begin
            s_next.tone = rmc_pkg::TONE_OFF;
            s_next.clen = 4'h0;
        end

        s_next.status  = s_next.buf_valid;
        s_next.link_en = normal;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            s_reg      <= '0;
            s_reg.addr <= rmc_pkg::DEF_ADDR;
            s_reg.chan <= rmc_pkg::DEF_CHAN;
            s_reg.tone <= rmc_pkg::TONE_OFF;
            s_reg.rxd  <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // registered outputs add one clock cycle of delay
    assign RF_TX_VALID = s_reg.rf_tx_valid;
    assign RF_TX_DATA  = s_reg.rf_tx_data;
    assign RF_LINK_EN  = s_reg.link_en;
    assign RF_TONE     = s_reg.tone;
    assign NODE_ADDR   = s_reg.addr;
    assign NODE_CHAN   = s_reg.chan;
    assign NV_WR       = s_reg.nv_wr;
    assign link.rxd    = s_reg.rxd;
    assign link.status = s_reg.status;

endmodule // rmc_modem

// ==== pkg/rmc_pkg.sv ====
package rmc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // serial timebase
    localparam int          CLK_HZ      = 100_000_000;
    localparam int          BAUD_HZ     = 9600;
    localparam int          BIT_CYC     = (CLK_HZ + BAUD_HZ / 2) / BAUD_HZ;
    localparam int          CNT_W       = 14;
    typedef logic [CNT_W-1:0] rmc_cnt_t;
    localparam logic [3:0]  RX_STOP_IDX = 4'h9;
    localparam logic [3:0]  TX_LAST_IDX = 4'h9;

    ////////////////////////////////////////////////////////////////////////
    // characters and command strings
    localparam logic [7:0]  CH_CR       = 8'h0d;
    localparam logic [7:0]  CH_TILDE    = 8'h7e;
    localparam logic [7:0]  CH_HASH     = 8'h23;
    localparam logic [7:0]  CH_ZERO     = 8'h30;
    localparam logic [7:0]  CH_ADDR_MAX = 8'h37;
    localparam logic [7:0]  CH_CHAN_MAX = 8'h34;
    localparam logic [31:0] CMD_ADDR    = 32'h41444452;
    localparam logic [31:0] CMD_CHAN    = 32'h4348414e;
    localparam logic [79:0] CMD_SAVE    = 80'h53455450524f4752414d;
    localparam logic [47:0] CMD_PLAIN   = 48'h4e4f544f4e45;
    localparam logic [47:0] CMD_LOW     = 48'h4c46544f4e45;
    localparam logic [47:0] CMD_HIGH    = 48'h4846544f4e45;
    localparam logic [3:0]  LEN_HASH    = 4'h1;
    localparam logic [3:0]  LEN_SEL     = 4'h5;
    localparam logic [3:0]  LEN_TONE    = 4'h6;
    localparam logic [3:0]  LEN_SAVE    = 4'ha;
    localparam logic [3:0]  LEN_OVER    = 4'hb;

    ////////////////////////////////////////////////////////////////////////
    // node setting
    localparam logic [2:0]  DEF_ADDR    = 3'h0;
    localparam logic [2:0]  DEF_CHAN    = 3'h0;
    typedef enum logic [1:0] {TONE_OFF, TONE_PLAIN, TONE_LOW, TONE_HIGH} rmc_tone_e;

    ////////////////////////////////////////////////////////////////////////
    // host register map
    localparam logic [3:0]  REG_CTRL    = 4'h0;
    localparam logic [3:0]  REG_TXD     = 4'h4;
    localparam logic [3:0]  REG_RXD     = 4'h8;
    localparam logic [3:0]  REG_STAT    = 4'hc;
    localparam int          CTRL_SETUP  = 0;
    localparam int          CTRL_EN     = 1;
    localparam int          RXD_VALID   = 8;
    localparam int          STAT_PIN    = 0;
    localparam int          STAT_TXBUSY = 1;
    localparam int          STAT_RXV    = 2;

endpackage

// ==== pkg/rmc_link_if.sv ====
interface rmc_link_if;
    // host to modem
    logic setup_n;
    logic enable_n;
    logic txd;
    // modem to host
    logic rxd;
    logic status;

    modport modem (input setup_n, enable_n, txd, output rxd, status);
    modport host  (output setup_n, enable_n, txd, input rxd, status);
endinterface

// ==== hdl/rmc_host.sv ====
module rmc_host #(
    parameter int BIT_CYC = rmc_pkg::BIT_CYC
) (
    // clock and reset
    input  wire logic         CORE_CLK,
    input  wire logic         SYS_RST,
    // avalon-mm slave
    input  wire logic [3:0]   AVS_ADDRESS,
    input  wire logic         AVS_READ,
    input  wire logic         AVS_WRITE,
    input  wire logic [31:0]  AVS_WRITEDATA,
    output logic [31:0]       AVS_READDATA,
    output logic              AVS_WAITREQUEST,
    // modem link
    rmc_link_if.host          link
);

    localparam rmc_pkg::rmc_cnt_t BIT_LAST = rmc_pkg::rmc_cnt_t'(BIT_CYC - 1);
    localparam rmc_pkg::rmc_cnt_t BIT_HALF = rmc_pkg::rmc_cnt_t'(BIT_CYC / 2);

    typedef struct packed {
        logic               setup_n;
        logic               enable_n;
        logic               wreq;
        logic [31:0]        rdata;
        logic               tx_busy;
        rmc_pkg::rmc_cnt_t  tx_cnt;
        logic [3:0]         tx_bit;
        logic [9:0]         tx_sh;
        logic               txd;
        logic               rx_busy;
        rmc_pkg::rmc_cnt_t  rx_cnt;
        logic [3:0]         rx_bit;
        logic [7:0]         rx_sh;
        logic               rx_valid;
        logic [7:0]         rx_ch;
    } rmc_host_s;

    rmc_host_s s_reg;
    rmc_host_s s_next;
    logic      req;
    logic      ok;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_next = s_reg;
        req    = AVS_READ || AVS_WRITE;
        // no new byte while modem holds data
        ok     = !(AVS_WRITE && AVS_ADDRESS == rmc_pkg::REG_TXD && (s_reg.tx_busy || link.status));

        // transmitter, one stop bit
        if (s_reg.tx_busy) begin
            if (s_reg.tx_cnt != '0) begin
                s_next.tx_cnt = s_reg.tx_cnt - 1'b1;
            end else if (s_reg.tx_bit == 4'h0) begin
                s_next.tx_busy = 1'b0;
                s_next.txd     = 1'b1;
            end else begin
                s_next.tx_sh  = {1'b1, s_reg.tx_sh[9:1]};
                s_next.txd    = s_reg.tx_sh[1];
                s_next.tx_bit = s_reg.tx_bit - 1'b1;
                s_next.tx_cnt = BIT_LAST;
            end
        end

        // receiver
        if (!s_reg.rx_busy) begin
            if (!link.rxd) begin
                s_next.rx_busy = 1'b1;
                s_next.rx_cnt  = BIT_HALF;
                s_next.rx_bit  = 4'h0;
            end
        end else if (s_reg.rx_cnt != '0) begin
            s_next.rx_cnt = s_reg.rx_cnt - 1'b1;
        end else begin
            s_next.rx_cnt = BIT_LAST;
            s_next.rx_bit = s_reg.rx_bit + 1'b1;
            if (s_reg.rx_bit == 4'h0) begin
                s_next.rx_busy = !link.rxd;
            end else if (s_reg.rx_bit == rmc_pkg::RX_STOP_IDX) begin
                s_next.rx_busy = 1'b0;
            end else begin
                s_next.rx_sh = {link.rxd, s_reg.rx_sh[7:1]};
            end
        end

        // bus access: grant, then commit on the low-waitrequest edge
        if (!s_reg.wreq) begin
            s_next.wreq = 1'b1;
            if (AVS_WRITE && AVS_ADDRESS == rmc_pkg::REG_CTRL) begin
                s_next.setup_n  = !AVS_WRITEDATA[rmc_pkg::CTRL_SETUP];
                s_next.enable_n = !AVS_WRITEDATA[rmc_pkg::CTRL_EN];
            end
            if (AVS_WRITE && AVS_ADDRESS == rmc_pkg::REG_TXD) begin
                s_next.tx_busy = 1'b1;
                s_next.tx_sh   = {1'b1, AVS_WRITEDATA[7:0], 1'b0};
                s_next.txd     = 1'b0;
                s_next.tx_bit  = rmc_pkg::TX_LAST_IDX;
                s_next.tx_cnt  = BIT_LAST;
            end
            // clear only a byte that was handed out, one landing at grant stays
            if (AVS_READ && AVS_ADDRESS == rmc_pkg::REG_RXD && s_reg.rdata[rmc_pkg::RXD_VALID]) begin
                s_next.rx_valid = 1'b0;
            end
        end else if (req && ok) begin
            s_next.wreq  = 1'b0;
            s_next.rdata = 32'h00000000;
            if (AVS_READ) begin
                unique case (AVS_ADDRESS)
                    rmc_pkg::REG_CTRL: begin
                        s_next.rdata[rmc_pkg::CTRL_SETUP] = !s_reg.setup_n;
                        s_next.rdata[rmc_pkg::CTRL_EN]    = !s_reg.enable_n;
                    end
                    rmc_pkg::REG_RXD: begin
                        s_next.rdata[7:0]                = s_reg.rx_ch;
                        s_next.rdata[rmc_pkg::RXD_VALID] = s_reg.rx_valid;
                    end
                    rmc_pkg::REG_STAT: begin
                        s_next.rdata[rmc_pkg::STAT_PIN]    = link.status;
                        s_next.rdata[rmc_pkg::STAT_TXBUSY] = s_reg.tx_busy;
                        s_next.rdata[rmc_pkg::STAT_RXV]    = s_reg.rx_valid;
                    end
                    default: s_next.rdata = 32'h00000000;
                endcase
            end
        end

        // new character wins over a read clear
        if (s_reg.rx_busy && s_reg.rx_cnt == '0 && s_reg.rx_bit == rmc_pkg::RX_STOP_IDX && link.rxd) begin
            s_next.rx_valid = 1'b1;
            s_next.rx_ch    = s_reg.rx_sh;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            s_reg          <= '0;
            s_reg.setup_n  <= 1'b1;
            s_reg.enable_n <= 1'b1;
            s_reg.wreq     <= 1'b1;
            s_reg.txd      <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign AVS_READDATA    = s_reg.rdata;
    assign AVS_WAITREQUEST = s_reg.wreq;
    assign link.setup_n    = s_reg.setup_n;
    assign link.enable_n   = s_reg.enable_n;
    assign link.txd        = s_reg.txd;

endmodule // rmc_host

// ==== bench/rmc_link_monitor.sv ====
module rmc_link_monitor #(
    parameter int BIT_CYC = 16
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // link lines
    input wire logic setup_n,
    input wire logic enable_n,
    input wire logic txd,
    input wire logic rxd,
    input wire logic status
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ECHO_MIN = 9 * BIT_CYC;
    localparam int ECHO_MAX = 21 * BIT_CYC;
    logic [1:0]  ln;
    logic [1:0]  st;
    logic [1:0]  q_reg;
    logic [1:0]  busy_reg;
    logic [15:0] cnt_reg [2];
    assign ln = {txd, rxd};
    // frame start: falling line while no frame runs
    assign st = ~busy_reg & q_reg & ~ln;
    always_ff @(posedge CORE_CLK) begin
        for (int i = 0; i < 2; i++) begin
            q_reg[i] <= SYS_RST | ln[i];
            if (SYS_RST) begin
                busy_reg[i] <= 1'b0;
                cnt_reg[i] <= 16'h0;
            end else if (st[i]) begin
                busy_reg[i] <= 1'b1;
                cnt_reg[i] <= 16'h1;
            end else if (busy_reg[i]) begin
                busy_reg[i] <= (cnt_reg[i] != 16'(10 * BIT_CYC - 1));
                cnt_reg[i] <= cnt_reg[i] + 16'h1;
            end
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////////////////////////////////////
    a_reset_idle: assert property (disable iff (1'b0) SYS_RST |=> rxd && txd && setup_n && enable_n && !status)
        else $error("link not idle after reset");
    a_echo_setup: assert property (st[1] && !setup_n && !enable_n |-> ##[ECHO_MIN:ECHO_MAX] st[0])
        else $error("no echo frame");
    a_rxd_start_low: assert property (busy_reg[0] && cnt_reg[0] < BIT_CYC |-> !rxd)
        else $error("rxd start bit short");
    a_txd_start_low: assert property (busy_reg[1] && cnt_reg[1] < BIT_CYC |-> !txd)
        else $error("txd start bit short");
    a_rxd_bit_len: assert property (busy_reg[0] && cnt_reg[0] % BIT_CYC != 0 |-> $stable(rxd))
        else $error("rxd bit length wrong");
    a_txd_bit_len: assert property (busy_reg[1] && cnt_reg[1] % BIT_CYC != 0 |-> $stable(txd))
        else $error("txd bit length wrong");
    a_rxd_stop_high: assert property (busy_reg[0] && cnt_reg[0] > 9 * BIT_CYC |-> rxd)
        else $error("rxd stop bit low");
    a_txd_stop_high: assert property (busy_reg[1] && cnt_reg[1] > 9 * BIT_CYC |-> txd)
        else $error("txd stop bit low");
    a_quiet_disabled: assert property (st[0] |-> !enable_n)
        else $error("rxd frame while disabled");
    a_status_normal: assert property ($rose(status) |-> $past(setup_n) && !$past(enable_n))
        else $error("status rose in setup");
    c_echo: cover property (st[0] && !setup_n);
    c_status: cover property ($rose(status));
    c_host_frame: cover property (st[1] && setup_n);
endmodule // rmc_link_monitor

// ==== bench/tb_radio_modem_setup_command_port.sv ====
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t %h vs %h", $time, a, b); end end
module tb_radio_modem_setup_command_port;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int B = 16;
    localparam int LIM = 40 * B;
    logic clk, rst, rd, wr, wq, nv_done, nv_wr, rf_en, tx_v, rx_v, saw_st;
    logic [3:0] adr;
    logic [31:0] wdat, rdat, got;
    logic [2:0] nv_a, nv_c, n_a, n_c, rx_a, rx_c, ea, ec;
    logic [7:0] tx_d, rx_d, last_tx, dg;
    logic [4:0] nv_sh;
    rmc_pkg::rmc_tone_e tone;
    int n_errors, n_compared, n_tx, n_nv, seed;
    string s;
    logic [47:0] tc [4] = '{rmc_pkg::CMD_PLAIN, rmc_pkg::CMD_LOW, 48'(rmc_pkg::CH_HASH), rmc_pkg::CMD_HIGH};
    rmc_pkg::rmc_tone_e te [4] = '{rmc_pkg::TONE_PLAIN, rmc_pkg::TONE_LOW, rmc_pkg::TONE_OFF, rmc_pkg::TONE_HIGH};
    rmc_link_if link();
    rmc_host #(.BIT_CYC(B)) u_rmc_host (.CORE_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .link(link));
    rmc_modem #(.BIT_CYC(B)) u_rmc_modem (.CORE_CLK(clk), .SYS_RST(rst), .link(link), .NV_ADDR(nv_a),
        .NV_CHAN(nv_c), .NV_DONE(nv_done), .NV_WR(nv_wr), .NODE_ADDR(n_a), .NODE_CHAN(n_c), .RF_LINK_EN(rf_en),
        .RF_TX_VALID(tx_v), .RF_TX_DATA(tx_d), .RF_TONE(tone), .RF_RX_VALID(rx_v), .RF_RX_DATA(rx_d),
        .RF_RX_ADDR(rx_a), .RF_RX_CHAN(rx_c));
    rmc_link_monitor #(.BIT_CYC(B)) u_rmc_link_monitor (.CORE_CLK(clk), .SYS_RST(rst), .setup_n(link.setup_n),
        .enable_n(link.enable_n), .txd(link.txd), .rxd(link.rxd), .status(link.status));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // storage answers a write after a few cycles
    always @(posedge clk) begin
        nv_sh <= {nv_sh[3:0], nv_wr};
        nv_done <= nv_sh[4];
        if (nv_wr === 1'b1) n_nv++;
        if (tx_v === 1'b1) n_tx++;
        if (tx_v === 1'b1) last_tx = tx_d;
        if (link.status === 1'b1) saw_st = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            k++;
        end while (wq !== 1'b0 && k < LIM);
        got = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (wq !== 1'b0) begin
            n_errors++;
            $display("[FAIL] %0t bus timeout", $time);
            results();
        end
    endtask
    task automatic rx_poll(input logic [7:0] c);
        for (int k = 0; k < 300; k++) begin
            bus(1'b0, rmc_pkg::REG_RXD, 32'h0);
            if (got[rmc_pkg::RXD_VALID] === 1'b1) break;
        end
        `CHK(got[8:0], {1'b1, c})
    endtask
    task automatic cmd(input string t);
        for (int i = 0; i < t.len(); i++) begin
            bus(1'b1, rmc_pkg::REG_TXD, {24'h0, t[i]});
            rx_poll(t[i]);
        end
    endtask
    function automatic logic [2:0] exp_sel(input logic [7:0] d, input logic [7:0] mx, input logic [2:0] cur);
        return (d >= rmc_pkg::CH_ZERO && d <= mx) ? d[2:0] : cur;
    endfunction
    // command text from its packed character code, first character highest
    function automatic string str(input logic [79:0] v, input int n);
        string r;
        r = "";
        for (int i = n - 1; i >= 0; i--) r = $sformatf("%s%c", r, v[8 * i +: 8]);
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hb8788a2c;
        {rst, rd, wr, rx_v, saw_st, nv_done} = 6'h20;
        {adr, wdat, rx_d, rx_a, rx_c, nv_sh} = '0;
        {n_errors, n_compared, n_tx, n_nv} = '0;
        nv_a = 3'($random(seed));
        nv_c = 3'($unsigned($random(seed)) % 5);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        {ea, ec} = {nv_a, nv_c};
        `CHK({n_a, n_c}, {ea, ec})
        bus(1'b0, 4'h2, 32'h0);
        `CHK(got, 32'h0)
        $display("test reset done");
        bus(1'b1, rmc_pkg::REG_CTRL, 32'h3);
        repeat (4) @(posedge clk);
        `CHK(rf_en, 1'b0)
        for (int t = 0; t < 8; t++) begin
            dg = (t < 2) ? 8'h38 - 8'(t * 3) : 8'h30 + 8'($unsigned($random(seed)) % 10);
            s = t[0] ? str({rmc_pkg::CMD_CHAN, dg}, 5) : str({rmc_pkg::CMD_ADDR, dg}, 5);
            cmd(s);
            `CHK({n_a, n_c}, {ea, ec})
            cmd("\r");
            if (t[0]) ec = exp_sel(dg, rmc_pkg::CH_CHAN_MAX, ec);
            else ea = exp_sel(dg, rmc_pkg::CH_ADDR_MAX, ea);
            `CHK({n_a, n_c}, {ea, ec})
        end
        cmd("addr1\r");
        `CHK({n_a, n_c}, {ea, ec})
        foreach (tc[i]) begin
            cmd({str(tc[i], (te[i] == rmc_pkg::TONE_OFF) ? 1 : 6), "\r"});
            `CHK(tone, te[i])
        end
        cmd({str(rmc_pkg::CMD_SAVE, 10), "\r"});
        rx_poll(rmc_pkg::CH_TILDE);
        `CHK(n_nv, 1)
        $display("test setup done");
        bus(1'b1, rmc_pkg::REG_CTRL, 32'h2);
        repeat (4) @(posedge clk);
        `CHK({rf_en, tone}, {1'b1, rmc_pkg::TONE_OFF})
        for (int t = 0; t < 3; t++) begin
            dg = 8'($random(seed));
            bus(1'b1, rmc_pkg::REG_TXD, {24'h0, dg});
            for (int k = 0; k < LIM && n_tx == t; k++) @(posedge clk);
            `CHK({n_tx, last_tx}, {t + 1, dg})
        end
        bus(1'b0, rmc_pkg::REG_RXD, 32'h0);
        `CHK(got[8], 1'b0)
        $display("test normal done");
        for (int t = 0; t < 4; t++) begin
            saw_st = 1'b0;
            dg = 8'($random(seed));
            @(posedge clk);
            rx_v <= 1'b1;
            rx_d <= dg;
            rx_a <= ea ^ 3'(t[0]);
            rx_c <= ec ^ 3'(t[1]);
            @(posedge clk);
            rx_v <= 1'b0;
            repeat (12 * B) @(posedge clk);
            `CHK(saw_st, t == 0)
            bus(1'b0, rmc_pkg::REG_RXD, 32'h0);
            `CHK(got[8], t == 0)
            if (t == 0) `CHK(got[7:0], dg)
        end
        // second radio byte is dropped when the host byte ends, only the first reaches the host
        dg = 8'($random(seed));
        bus(1'b1, rmc_pkg::REG_TXD, 32'h5a);
        repeat (100) @(posedge clk);
        rx_v <= 1'b1;
        rx_d <= dg;
        rx_a <= ea;
        rx_c <= ec;
        @(posedge clk);
        rx_d <= ~dg;
        @(posedge clk);
        rx_v <= 1'b0;
        repeat (40 * B) @(posedge clk);
        bus(1'b0, rmc_pkg::REG_RXD, 32'h0);
        `CHK(got[8:0], {1'b1, dg})
        `CHK({n_tx, last_tx, link.status}, {32'd4, 8'h5a, 1'b0})
        $display("test radio done");
        results();
    end
endmodule // tb_radio_modem_setup_command_port
